// [verilog/cdt_map.svh]
`ifndef CDT_MAP_SVH
`define CDT_MAP_SVH
`define CDT_ADDR_CLK_ZERO 8'h41
`define CDT_ADDR_CLK_TRAIL 8'h42
`define CDT_ADDR_CLK_POST 8'h43
`define CDT_ADDR_DAT_PREP 8'h44
`define CDT_ADDR_DAT_ZERO 8'h45
`define CDT_ADDR_DAT_TRAIL 8'h46
`define CDT_ADDR_DAT_EXIT 8'h47
`define CDT_ADDR_PLX 8'h48
`define CDT_ADDR_RATE 8'h4F
`define CDT_OV_BIT 7
`define CDT_VAL_MSB 6
`define CDT_RATE_400 3'h0
`define CDT_RATE_800 3'h1
`define CDT_RATE_1200 3'h2
`define CDT_RATE_1500 3'h3
`define CDT_RATE_1600 3'h4
`define CDT_RATE_RESET 3'h1
`define CDT_RESET_CLK_ZERO 7'h1B
`define CDT_RESET_CLK_TRAIL 7'h0B
`define CDT_RESET_CLK_POST 7'h0A
`define CDT_RESET_DAT_PREP 7'h06
`define CDT_RESET_DAT_ZERO 7'h0C
`define CDT_RESET_DAT_TRAIL 7'h08
`define CDT_RESET_DAT_EXIT 7'h0B
`define CDT_RESET_PLX 7'h06
`define CDT_AUTO400_CLK_ZERO 7'h0E
`endif

// [verilog/cdt_pkg.sv]
package cdt_pkg;
	typedef logic [6:0] cdt_value_t;
	typedef logic [2:0] cdt_rate_t;
	typedef enum logic [2:0] {
		CDT_IDLE = 3'h1,
		CDT_LOAD = 3'h2,
		CDT_DONE = 3'h4
	} cdt_state_t;
endpackage : cdt_pkg

// [verilog/cdt_auto_table.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"
module cdt_auto_table
	import cdt_pkg::*;
(
	input wire cdt_rate_t rate,
	output cdt_value_t clk_zero,
	output cdt_value_t clk_trail,
	output cdt_value_t clk_post,
	output cdt_value_t dat_prep,
	output cdt_value_t dat_zero,
	output cdt_value_t dat_trail,
	output cdt_value_t dat_exit,
	output cdt_value_t plx
);
	// 800 Mbps row equals reset values; other rows scale roughly with rate
	always_comb begin
		clk_zero = `CDT_RESET_CLK_ZERO;
		clk_trail = `CDT_RESET_CLK_TRAIL;
		clk_post = `CDT_RESET_CLK_POST;
		dat_prep = `CDT_RESET_DAT_PREP;
		dat_zero = `CDT_RESET_DAT_ZERO;
		dat_trail = `CDT_RESET_DAT_TRAIL;
		dat_exit = `CDT_RESET_DAT_EXIT;
		plx = `CDT_RESET_PLX;
		case (rate)
			`CDT_RATE_400: begin
				clk_zero = `CDT_AUTO400_CLK_ZERO;
				clk_trail = 7'h06;
				clk_post = 7'h07;
				dat_prep = 7'h03;
				dat_zero = 7'h06;
				dat_trail = 7'h05;
				dat_exit = 7'h06;
				plx = 7'h03;
			end
			`CDT_RATE_1200: begin
				clk_zero = 7'h29;
				clk_trail = 7'h10;
				clk_post = 7'h0D;
				dat_prep = 7'h09;
				dat_zero = 7'h12;
				dat_trail = 7'h0C;
				dat_exit = 7'h10;
				plx = 7'h09;
			end
			`CDT_RATE_1500, `CDT_RATE_1600: begin
				clk_zero = 7'h36;
				clk_trail = 7'h15;
				clk_post = 7'h10;
				dat_prep = 7'h0C;
				dat_zero = 7'h18;
				dat_trail = 7'h10;
				dat_exit = 7'h16;
				plx = 7'h0C;
			end
			default: begin
			end
		endcase
	end
endmodule : cdt_auto_table
`default_nettype wire

// [verilog/cdt_timing_field.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"
module cdt_timing_field
	import cdt_pkg::*;
#(
	parameter cdt_value_t RESET_VALUE = 7'h00
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire cdt_value_t auto_value,
	output logic [7:0] reg_view,
	output cdt_value_t timing_value
);
	logic override_reg;
	cdt_value_t value_reg;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			override_reg <= 1'b0;
		end else if (wr_en) begin
			override_reg <= wr_data[`CDT_OV_BIT];
		end
	end
	// value tracks auto while not overridden; an override write loads its own value from wr_data
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			value_reg <= RESET_VALUE;
		end else if (wr_en && wr_data[`CDT_OV_BIT]) begin
			value_reg <= wr_data[`CDT_VAL_MSB:0];
		end else if (!override_reg || wr_en) begin
			// a clearing write reverts at once, no stale programmed value
			value_reg <= auto_value;
		end
	end
	assign reg_view = {override_reg, value_reg};
	assign timing_value = value_reg;
endmodule : cdt_timing_field
`default_nettype wire

// [verilog/cdt_port0_timing.sv]
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"
module cdt_port0_timing
	import cdt_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output cdt_value_t CLK_ZERO_TIME,
	output cdt_value_t CLK_TRAIL_TIME,
	output cdt_value_t CLK_POST_TIME,
	output cdt_value_t DAT_PREP_TIME,
	output cdt_value_t DAT_ZERO_TIME,
	output cdt_value_t DAT_TRAIL_TIME,
	output cdt_value_t DAT_EXIT_TIME,
	output cdt_value_t PLX_TIME
);
	cdt_rate_t rate_reg;
	cdt_value_t a_czero, a_ctrail, a_cpost, a_dprep;
	cdt_value_t a_dzero, a_dtrail, a_dexit, a_plx;
	logic [7:0] v_czero, v_ctrail, v_cpost, v_dprep;
	logic [7:0] v_dzero, v_dtrail, v_dexit, v_plx;
	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;

	// lane rate select is software owned; automatic values follow it
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rate_reg <= `CDT_RATE_RESET;
		end else if (WR && ADDR == `CDT_ADDR_RATE) begin
			rate_reg <= WDATA[2:0];
		end
	end

	cdt_auto_table u_table (
		.rate(rate_reg),
		.clk_zero(a_czero),
		.clk_trail(a_ctrail),
		.clk_post(a_cpost),
		.dat_prep(a_dprep),
		.dat_zero(a_dzero),
		.dat_trail(a_dtrail),
		.dat_exit(a_dexit),
		.plx(a_plx)
	);

	cdt_timing_field #(.RESET_VALUE(`CDT_RESET_CLK_ZERO)) u_czero (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.wr_en(WR && ADDR == `CDT_ADDR_CLK_ZERO),
		.wr_data(WDATA),
		.auto_value(a_czero),
		.reg_view(v_czero),
		.timing_value(CLK_ZERO_TIME)
	);
	cdt_timing_field #(.RESET_VALUE(`CDT_RESET_CLK_TRAIL)) u_ctrail (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.wr_en(WR && ADDR == `CDT_ADDR_CLK_TRAIL),
		.wr_data(WDATA),
		.auto_value(a_ctrail),
		.reg_view(v_ctrail),
		.timing_value(CLK_TRAIL_TIME)
	);
	cdt_timing_field #(.RESET_VALUE(`CDT_RESET_CLK_POST)) u_cpost (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.wr_en(WR && ADDR == `CDT_ADDR_CLK_POST),
		.wr_data(WDATA),
		.auto_value(a_cpost),
		.reg_view(v_cpost),
		.timing_value(CLK_POST_TIME)
	);
	cdt_timing_field #(.RESET_VALUE(`CDT_RESET_DAT_PREP)) u_dprep (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.wr_en(WR && ADDR == `CDT_ADDR_DAT_PREP),
		.wr_data(WDATA),
		.auto_value(a_dprep),
		.reg_view(v_dprep),
		.timing_value(DAT_PREP_TIME)
	);
	cdt_timing_field #(.RESET_VALUE(`CDT_RESET_DAT_ZERO)) u_dzero (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.wr_en(WR && ADDR == `CDT_ADDR_DAT_ZERO),
		.wr_data(WDATA),
		.auto_value(a_dzero),
		.reg_view(v_dzero),
		.timing_value(DAT_ZERO_TIME)
	);
	cdt_timing_field #(.RESET_VALUE(`CDT_RESET_DAT_TRAIL)) u_dtrail (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.wr_en(WR && ADDR == `CDT_ADDR_DAT_TRAIL),
		.wr_data(WDATA),
		.auto_value(a_dtrail),
		.reg_view(v_dtrail),
		.timing_value(DAT_TRAIL_TIME)
	);
	cdt_timing_field #(.RESET_VALUE(`CDT_RESET_DAT_EXIT)) u_dexit (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.wr_en(WR && ADDR == `CDT_ADDR_DAT_EXIT),
		.wr_data(WDATA),
		.auto_value(a_dexit),
		.reg_view(v_dexit),
		.timing_value(DAT_EXIT_TIME)
	);
	cdt_timing_field #(.RESET_VALUE(`CDT_RESET_PLX)) u_plx (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.wr_en(WR && ADDR == `CDT_ADDR_PLX),
		.wr_data(WDATA),
		.auto_value(a_plx),
		.reg_view(v_plx),
		.timing_value(PLX_TIME)
	);

	// unmapped addresses read as zero
	always_comb begin
		case (ADDR)
			`CDT_ADDR_CLK_ZERO: rdata_next = v_czero;
			`CDT_ADDR_CLK_TRAIL: rdata_next = v_ctrail;
			`CDT_ADDR_CLK_POST: rdata_next = v_cpost;
			`CDT_ADDR_DAT_PREP: rdata_next = v_dprep;
			`CDT_ADDR_DAT_ZERO: rdata_next = v_dzero;
			`CDT_ADDR_DAT_TRAIL: rdata_next = v_dtrail;
			`CDT_ADDR_DAT_EXIT: rdata_next = v_dexit;
			`CDT_ADDR_PLX: rdata_next = v_plx;
			`CDT_ADDR_RATE: rdata_next = {5'h00, rate_reg};
			default: rdata_next = 8'h00;
		endcase
	end

	// read data held only in the cycle after the strobe
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_reg <= 8'h00;
		end else if (RD) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 8'h00;
		end
	end
	assign RDATA = rdata_reg;
endmodule : cdt_port0_timing
`default_nettype wire

// [test/cdt_port0_timing_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module cdt_port0_timing_sva
	import cdt_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire cdt_value_t CLK_ZERO_TIME,
	input wire cdt_value_t PLX_TIME
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_ov(a);
		WR && ADDR == a && WDATA[7];
	endsequence
	sequence s_rate;
		WR && ADDR == 8'h4F;
	endsequence
	property p_wr_zero;
		s_ov(8'h41) |=> CLK_ZERO_TIME == $past(WDATA[6:0]);
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("zero override");
	property p_wr_plx;
		s_ov(8'h48) |=> PLX_TIME == $past(WDATA[6:0]);
	endproperty
	a_wr_plx: assert property (p_wr_plx) else $error("plx override");
	property p_rd_zero;
		RD && ADDR == 8'h41 |=> RDATA[6:0] == $past(CLK_ZERO_TIME);
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("zero read");
	property p_rd_plx;
		RD && ADDR == 8'h48 |=> RDATA[6:0] == $past(PLX_TIME);
	endproperty
	a_rd_plx: assert property (p_rd_plx) else $error("plx read");
	property p_idle;
		!RD |=> RDATA == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("read data idle");
	property p_unm_rd;
		RD && ADDR == 8'h50 |=> RDATA == 8'h00;
	endproperty
	a_unm_rd: assert property (p_unm_rd) else $error("unmapped read");
	property p_hold;
		!WR && !$past(WR) |=> $stable(CLK_ZERO_TIME) && $stable(PLX_TIME);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved");
	// override taken just before a rate write must survive it
	property p_keep;
		s_ov(8'h41) ##1 s_rate |=> ##1 CLK_ZERO_TIME == $past(WDATA[6:0], 3);
	endproperty
	a_keep: assert property (p_keep) else $error("override lost");
endmodule : cdt_port0_timing_sva
bind cdt_port0_timing cdt_port0_timing_sva u_sva (.CLK, .RESET_N, .ADDR,
	.WDATA, .WR, .RD, .RDATA, .CLK_ZERO_TIME, .PLX_TIME);
`default_nettype wire

// [test/cdt_rx_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cdt_rx_model
	import cdt_pkg::*;
(
	input wire logic CLK,
	input wire cdt_value_t CLK_ZERO_TIME,
	input wire cdt_value_t PLX_TIME,
	output logic [13:0] seen
);
	// receiver latches the timing it applies to its next burst
	always_ff @(posedge CLK) begin
		seen <= {CLK_ZERO_TIME, PLX_TIME};
	end
endmodule : cdt_rx_model
`default_nettype wire

// [test/tb_cdt_port0_timing.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cdt_map.svh"
module tb_cdt_port0_timing
	import cdt_pkg::*;
;
	logic CLK, RESET_N, WR, RD;
	logic [7:0] ADDR, WDATA, d;
	wire logic [7:0] RDATA;
	wire cdt_value_t t [8];
	wire logic [13:0] seen;
	int num_errors = 0;
	int total_checks = 0;
	cdt_value_t rv [8] = '{`CDT_RESET_CLK_ZERO, `CDT_RESET_CLK_TRAIL,
		`CDT_RESET_CLK_POST, `CDT_RESET_DAT_PREP, `CDT_RESET_DAT_ZERO,
		`CDT_RESET_DAT_TRAIL, `CDT_RESET_DAT_EXIT, `CDT_RESET_PLX};
	cdt_port0_timing dut_u (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.CLK_ZERO_TIME(t[0]), .CLK_TRAIL_TIME(t[1]), .CLK_POST_TIME(t[2]),
		.DAT_PREP_TIME(t[3]), .DAT_ZERO_TIME(t[4]), .DAT_TRAIL_TIME(t[5]),
		.DAT_EXIT_TIME(t[6]), .PLX_TIME(t[7]));
	cdt_rx_model rx_u (.CLK(CLK), .CLK_ZERO_TIME(t[0]), .PLX_TIME(t[7]),
		.seen(seen));
	task end_sim;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// write leaves the strobe up so writes can run back to back
	task wr(input logic [7:0] a, input logic [7:0] v);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		RD <= 1'b0;
		@(posedge CLK);
	endtask : wr
	task idle;
		WR <= 1'b0;
		RD <= 1'b0;
		@(posedge CLK);
	endtask : idle
	task rd(input logic [7:0] a);
		ADDR <= a;
		RD <= 1'b1;
		WR <= 1'b0;
		@(posedge CLK);
		RD <= 1'b0;
		#1 d = RDATA;
		@(posedge CLK);
	endtask : rd
	task t_all(input int ov, input int base);
		for (int i = 0; i < 8; i++) begin
			rd(8'(8'h41 + i));
			chk("read", ov ? 8'(8'h80 + base + i) : {1'b0, rv[i]}, d);
			chk("out", ov ? 8'(base + i) : {1'b0, rv[i]}, {1'b0, t[i]});
		end
		$display("table pass done");
	endtask : t_all
	task t_override;
		wr(8'h41, 8'h05);
		idle();
		t_all(0, 0);
		for (int i = 0; i < 8; i++) begin
			wr(8'(8'h41 + i), 8'(8'h91 + i));
		end
		idle();
		t_all(1, 8'h11);
		chk("rx zero", 8'h11, {1'b0, seen[13:7]});
		chk("rx plx", 8'h18, {1'b0, seen[6:0]});
		rd(8'h50);
		chk("unmapped", 8'h00, d);
		$display("override test done");
	endtask : t_override
	task t_rate;
		wr(8'h41, 8'h9A);
		wr(8'h4F, {5'h00, `CDT_RATE_400});
		idle();
		idle();
		chk("kept", 8'h1A, {1'b0, t[0]});
		for (int i = 0; i < 8; i++) begin
			wr(8'(8'h41 + i), 8'h00);
		end
		idle();
		chk("auto", {1'b0, `CDT_AUTO400_CLK_ZERO}, {1'b0, t[0]});
		wr(8'h4F, {5'h00, `CDT_RATE_800});
		idle();
		idle();
		t_all(0, 0);
		$display("rate test done");
	endtask : t_rate
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	initial begin
		repeat (20000) @(posedge CLK);
		num_errors++;
		end_sim();
	end
	initial begin
		RESET_N = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 8'h00;
		WDATA = 8'h00;
		repeat (20) @(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
		t_all(0, 0);
		t_override();
		t_rate();
		end_sim();
	end
endmodule : tb_cdt_port0_timing
`default_nettype wire
